// [osr_defs.svh]
`ifndef OSR_DEFS_SVH
`define OSR_DEFS_SVH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define OSR_ADDR_W 4
`define OSR_ADDR_GROUP_A 4'h0
`define OSR_ADDR_GROUP_B 4'h1
`define OSR_ADDR_PROG 4'h2
`define OSR_ADDR_AUX 4'h3
`define OSR_ADDR_POL_LOW 4'h4
`define OSR_ADDR_POL_HIGH 4'h5
`define OSR_ADDR_MONITOR 4'h6

// ----------------------------------------------------------------
// Reset values of the routing and polarity registers
// ----------------------------------------------------------------
`define OSR_RST_GROUP_A 16'h2001
`define OSR_RST_GROUP_B 16'h0300
`define OSR_RST_PROG 16'h0654
`define OSR_RST_AUX 16'h0000
`define OSR_RST_POL_LOW 16'h0000
`define OSR_RST_POL_HIGH 16'h0000

// ----------------------------------------------------------------
// Field layout: one 4-bit digit per field, lowest digit first
// ----------------------------------------------------------------
`define OSR_DIGIT_W 4
`define OSR_NUM_SIG 15
`define OSR_NUM_POS 6
`define OSR_CODE_OFF 4'h0
`define OSR_CODE_MAX 4'h6
`define OSR_DIGIT_INVERT 4'h1

// ----------------------------------------------------------------
// Status signal indices on status_in
// ----------------------------------------------------------------
`define OSR_SIG_POS_COMPLETE 0
`define OSR_SIG_BRAKE 6
`define OSR_SIG_PROG_ZERO 8
`define OSR_SIG_PROG_THREE 11
`define OSR_SIG_PROG_FOUR 12
`define OSR_SIG_HOMING_DONE 13
`define OSR_SIG_REF_DIST 14

`endif

// [osr_field_decode.sv]
`timescale 1ns/1ps
`include "osr_defs.svh"

// Turns one routing digit into a one-hot position select
module osr_field_decode (
  input wire osr_pkg::osr_code_t code,
  output logic [`OSR_NUM_POS-1:0] sel
);

  // Codes 1..6 pick a position; 0 and codes above 6 leave it unrouted
  genvar p;
  generate
    for (p = 0; p < `OSR_NUM_POS; p = p + 1) begin : g_pos
      assign sel[p] = (code == 4'(p + 1));
    end
  endgenerate

endmodule

// [osr_load_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Connector loads
// ------------------------------------------------------------
// The far-side controller latches each position once per clock.
// Its input filter therefore sees every level one cycle late.
module osr_load_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [5:0] pin_out,
  output logic [5:0] load_state
);
  // Capture the driven levels
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      load_state <= 6'h00;
    end else begin
      load_state <= pin_out;
    end
  end
endmodule

// [osr_pin_driver.sv]
`timescale 1ns/1ps
`include "osr_defs.svh"

// Drives one connector position from the signals routed onto it
module osr_pin_driver #(
  parameter int NUM_SIG = `OSR_NUM_SIG
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [NUM_SIG-1:0] hits,
  input wire logic invert,
  output logic pin
);

  // Several signals on one position are ORed rather than refused
  wire any_hit = |hits;
  wire next_pin = any_hit ^ invert;

  // Registered so the pin never glitches while routing changes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin <= 1'b0;
    end else begin
      pin <= next_pin;
    end
  end

endmodule

// [osr_pkg.sv]
package osr_pkg;
  // One routing digit
  typedef logic [3:0] osr_code_t;
  // Output positions in the order of the routing codes 1 to 6
  typedef enum logic [2:0] {
    OSR_POS_25_26 = 3'h0,
    OSR_POS_27_28 = 3'h1,
    OSR_POS_29_30 = 3'h2,
    OSR_POS_37 = 3'h3,
    OSR_POS_38 = 3'h4,
    OSR_POS_39 = 3'h5
  } osr_pos_t;
endpackage

// [osr_router.sv]
`timescale 1ns/1ps
`include "osr_defs.svh"

// Contract
// - Each status signal goes to the position its digit picks: 1..6, or 0 for none.
// - Clearing the positioning-complete digit frees 25/26 for the brake when set to 1.
// - Low polarity digits invert 25/26, 27/28, 29/30, 37 when set to 1.
// - High polarity digits invert 38 then 39 when set to 1.
// - Present states of all routed outputs are readable through the monitor register.
module osr_router (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [`OSR_NUM_SIG-1:0] status_in,
  input wire logic [`OSR_ADDR_W-1:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  output logic [`OSR_NUM_POS-1:0] pin_out
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0] status_routing_group_a;
  logic [15:0] status_routing_group_b;
  logic [15:0] programmable_output_routing;
  logic [15:0] auxiliary_output_routing;
  logic [15:0] output_polarity_low;
  logic [15:0] output_polarity_high;

  // Write decode
  wire wr_group_a = wr_en && (addr == `OSR_ADDR_GROUP_A);
  wire wr_group_b = wr_en && (addr == `OSR_ADDR_GROUP_B);
  wire wr_prog = wr_en && (addr == `OSR_ADDR_PROG);
  wire wr_aux = wr_en && (addr == `OSR_ADDR_AUX);
  wire wr_pol_low = wr_en && (addr == `OSR_ADDR_POL_LOW);
  wire wr_pol_high = wr_en && (addr == `OSR_ADDR_POL_HIGH);

  // Routing registers; new digits take effect on the next pin update
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_routing_group_a <= `OSR_RST_GROUP_A;
      status_routing_group_b <= `OSR_RST_GROUP_B;
      programmable_output_routing <= `OSR_RST_PROG;
      auxiliary_output_routing <= `OSR_RST_AUX;
    end else begin
      if (wr_group_a) begin
        status_routing_group_a <= wr_data;
      end
      if (wr_group_b) begin
        status_routing_group_b <= wr_data;
      end
      if (wr_prog) begin
        programmable_output_routing <= wr_data;
      end
      if (wr_aux) begin
        auxiliary_output_routing <= wr_data;
      end
    end
  end

  // Polarity registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      output_polarity_low <= `OSR_RST_POL_LOW;
      output_polarity_high <= `OSR_RST_POL_HIGH;
    end else begin
      if (wr_pol_low) begin
        output_polarity_low <= wr_data;
      end
      if (wr_pol_high) begin
        output_polarity_high <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Routing fields
  // ----------------------------------------------------------------
  // The fourth digit of the auxiliary register carries no signal
  wire [63:0] all_fields = {auxiliary_output_routing, programmable_output_routing,
                            status_routing_group_b, status_routing_group_a};

  // Per-signal one-hot position select, flattened signal by signal
  wire [`OSR_NUM_SIG*`OSR_NUM_POS-1:0] sel_flat;
  // Per-position signal hits, flattened position by position
  wire [`OSR_NUM_POS*`OSR_NUM_SIG-1:0] hits_flat;

  genvar s;
  genvar p;
  generate
    for (s = 0; s < `OSR_NUM_SIG; s = s + 1) begin : g_sig
      osr_field_decode u_decode (
        .code(osr_pkg::osr_code_t'(all_fields[s*`OSR_DIGIT_W +: `OSR_DIGIT_W])),
        .sel(sel_flat[s*`OSR_NUM_POS +: `OSR_NUM_POS])
      );
      for (p = 0; p < `OSR_NUM_POS; p = p + 1) begin : g_hit
        assign hits_flat[p*`OSR_NUM_SIG + s] = status_in[s] && sel_flat[s*`OSR_NUM_POS + p];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Polarity and pin drivers
  // ----------------------------------------------------------------
  // Only a digit of exactly 1 inverts; other digit values leave the pin true
  wire [`OSR_NUM_POS-1:0] invert;
  assign invert[0] = (output_polarity_low[3:0] == `OSR_DIGIT_INVERT);
  assign invert[1] = (output_polarity_low[7:4] == `OSR_DIGIT_INVERT);
  assign invert[2] = (output_polarity_low[11:8] == `OSR_DIGIT_INVERT);
  assign invert[3] = (output_polarity_low[15:12] == `OSR_DIGIT_INVERT);
  assign invert[4] = (output_polarity_high[3:0] == `OSR_DIGIT_INVERT);
  assign invert[5] = (output_polarity_high[7:4] == `OSR_DIGIT_INVERT);

  generate
    for (p = 0; p < `OSR_NUM_POS; p = p + 1) begin : g_pin
      osr_pin_driver #(
        .NUM_SIG(`OSR_NUM_SIG)
      ) u_pin (
        .ref_clk(ref_clk),
        .reset(reset),
        .hits(hits_flat[p*`OSR_NUM_SIG +: `OSR_NUM_SIG]),
        .invert(invert[p]),
        .pin(pin_out[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Monitor: connector levels low, unused bits zero
  wire [15:0] monitor_word = {10'h000, pin_out};

  logic [15:0] read_mux;
  always_comb begin
    unique case (addr)
      `OSR_ADDR_GROUP_A: read_mux = status_routing_group_a;
      `OSR_ADDR_GROUP_B: read_mux = status_routing_group_b;
      `OSR_ADDR_PROG: read_mux = programmable_output_routing;
      `OSR_ADDR_AUX: read_mux = auxiliary_output_routing;
      `OSR_ADDR_POL_LOW: read_mux = output_polarity_low;
      `OSR_ADDR_POL_HIGH: read_mux = output_polarity_high;
      `OSR_ADDR_MONITOR: read_mux = monitor_word;
      default: read_mux = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the strobe, else zero
  wire [15:0] next_rd_data = rd_en ? read_mux : 16'h0000;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wire [3:0] done_digit = status_routing_group_a[3:0];
  wire [3:0] brake_digit = status_routing_group_b[11:8];
  wire [`OSR_NUM_SIG-1:0] hits_p0 = hits_flat[0 +: `OSR_NUM_SIG];
  wire [`OSR_NUM_SIG-1:0] hits_p3 = hits_flat[3*`OSR_NUM_SIG +: `OSR_NUM_SIG];
  wire [`OSR_NUM_SIG-1:0] hits_p5 = hits_flat[5*`OSR_NUM_SIG +: `OSR_NUM_SIG];

  sequence s_brake_alone;
    done_digit == `OSR_CODE_OFF && brake_digit == 4'h1 && !invert[0] && status_in[`OSR_SIG_BRAKE];
  endsequence

  sequence s_pol_low_write;
    wr_pol_low && wr_data[15:12] == `OSR_DIGIT_INVERT && hits_p3 == '0;
  endsequence

  route_done_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (done_digit == 4'h1 && status_in[`OSR_SIG_POS_COMPLETE] && !invert[0]) |=> pin_out[0])
    else $error("positioning complete not driven on 25/26");

  unrouted_pin_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (hits_p0 == '0 && !invert[0]) |=> !pin_out[0])
    else $error("unrouted position 25/26 driven active");

  brake_swap_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_brake_alone |=> pin_out[0])
    else $error("brake not placed on freed 25/26");

  pol_low_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_pol_low_write ##1 (hits_p3 == '0) |=> pin_out[3])
    else $error("pin 37 not inverted two cycles after polarity write");

  pol_high_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (output_polarity_high[7:4] == `OSR_DIGIT_INVERT && hits_p5 == '0) |=> pin_out[5])
    else $error("pin 39 not inverted by high polarity digit");

  monitor_read_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd_en && addr == `OSR_ADDR_MONITOR) |=> rd_data == {10'h000, $past(pin_out)})
    else $error("monitor read does not show pin levels");

  read_once_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !rd_en |=> rd_data == 16'h0000)
    else $error("read data held beyond one cycle");

  reset_default_a: assert property (
    @(posedge ref_clk)
    $fell(reset) |-> (auxiliary_output_routing[11:0] == 12'h000
      && programmable_output_routing[15:12] == 4'h0
      && output_polarity_low == 16'h0000 && output_polarity_high == 16'h0000))
    else $error("routing or polarity not at default after reset");

  // ----------------------------------------------------------------
  // Routing of the programmable and auxiliary signals
  // ----------------------------------------------------------------
  // Digit fields named for the checks below
  wire [3:0] prog_three_digit = programmable_output_routing[15:12];
  wire [3:0] prog_four_digit = auxiliary_output_routing[3:0];
  wire [3:0] homing_digit = auxiliary_output_routing[7:4];
  wire [3:0] ref_dist_digit = auxiliary_output_routing[11:8];
  wire [`OSR_NUM_SIG-1:0] hits_p4 = hits_flat[4*`OSR_NUM_SIG +: `OSR_NUM_SIG];

  // A write of code 1, then the signal active with no inversion
  sequence s_prog_zero_write;
    wr_prog && wr_data[3:0] == 4'h1;
  endsequence

  sequence s_prog_zero_active;
    status_in[`OSR_SIG_PROG_ZERO] && output_polarity_low[3:0] == `OSR_CODE_OFF;
  endsequence

  // Code 4 of the third programmable output lands on pin 37
  prog_three_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (prog_three_digit == 4'h4 && status_in[`OSR_SIG_PROG_THREE] && output_polarity_low[15:12] == `OSR_CODE_OFF)
    |=> pin_out[3])
    else $error("third programmable output not driven on 37");

  // Code 5 of the fourth programmable output lands on pin 38
  prog_four_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (prog_four_digit == 4'h5 && status_in[`OSR_SIG_PROG_FOUR] && output_polarity_high[3:0] == `OSR_CODE_OFF)
    |=> pin_out[4])
    else $error("fourth programmable output not driven on 38");

  // Code 6 of the homing output lands on pin 39
  homing_route_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (homing_digit == 4'h6 && status_in[`OSR_SIG_HOMING_DONE] && output_polarity_high[7:4] == `OSR_CODE_OFF)
    |=> pin_out[5])
    else $error("homing output not driven on 39");

  // Code 2 of the distribution output lands on 27/28
  ref_dist_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (ref_dist_digit == 4'h2 && status_in[`OSR_SIG_REF_DIST] && output_polarity_low[7:4] == `OSR_CODE_OFF)
    |=> pin_out[1])
    else $error("distribution output not driven on 27/28");

  // A fresh code reaches 25/26 two edges after its write
  route_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    s_prog_zero_write ##1 s_prog_zero_active |=> pin_out[0])
    else $error("new routing code not applied on the following update");

  // ----------------------------------------------------------------
  // Polarity, brake and read-back checks
  // ----------------------------------------------------------------
  // An active signal on an inverted position drives it low
  brake_inverted_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (brake_digit == 4'h1 && output_polarity_low[3:0] == `OSR_DIGIT_INVERT && status_in[`OSR_SIG_BRAKE])
    |=> !pin_out[0])
    else $error("inverted 25/26 not low while brake active");

  // Nothing active and no inversion keeps the position low
  pol_true_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (status_in == '0 && output_polarity_low[11:8] == `OSR_CODE_OFF) |=> !pin_out[2])
    else $error("29/30 active with no signal and no inversion");

  // Lowest high-polarity digit inverts pin 38
  pin38_invert_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (output_polarity_high[3:0] == `OSR_DIGIT_INVERT && hits_p4 == '0) |=> pin_out[4])
    else $error("pin 38 not inverted by high polarity digit");

  // Register reads return the stored word one cycle later
  read_reg_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd_en && addr == `OSR_ADDR_POL_HIGH) |=> rd_data == $past(output_polarity_high))
    else $error("high polarity word not read back");

  // Space above the monitor reads as zero
  unmapped_read_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    (rd_en && addr > `OSR_ADDR_MONITOR) |=> rd_data == 16'h0000)
    else $error("unmapped address returned data");

  // Routing word writes land whole at the next edge
  group_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr_group_a |=> status_routing_group_a == $past(wr_data))
    else $error("positioning complete routing word not written");

  // Pins and read data leave reset quiet
  reset_pins_a: assert property (
    @(posedge ref_clk)
    $fell(reset) |-> (pin_out == '0 && rd_data == 16'h0000))
    else $error("pins or read data not quiet after reset");

endmodule

// [tb_output_signal_router.sv]
`timescale 1ns/1ps
`include "osr_defs.svh"

module tb_output_signal_router;
  logic ref_clk, reset, wr_en, rd_en;
  logic [`OSR_NUM_SIG-1:0] status_in;
  logic [`OSR_ADDR_W-1:0] addr;
  logic [15:0] wr_data, rd_data;
  logic [`OSR_NUM_POS-1:0] pin_out, load_state, exp_pins;
  logic [31:0] rng, r;
  int bad_count, total_checks;
  int regs[6];

  osr_router dut (.ref_clk(ref_clk), .reset(reset), .status_in(status_in), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pin_out(pin_out));
  osr_load_model load (.ref_clk(ref_clk), .reset(reset), .pin_out(pin_out), .load_state(load_state));

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Digit codes 7..15 and polarity digits other than 1 count as off
  function automatic logic [5:0] route(logic [14:0] st);
    logic [5:0] p;
    int c;
    p = 6'h00;
    for (int i = 0; i < 15; i++) begin
      c = (regs[i / 4] >> (4 * (i % 4))) & 15;
      if (st[i] && c >= 1 && c <= 6) p[c - 1] = 1'b1;
    end
    for (int q = 0; q < 6; q++) begin
      c = (q < 4) ? (regs[4] >> (4 * q)) & 15 : (regs[5] >> (4 * (q - 4))) & 15;
      if (c == 1) p[q] = ~p[q];
    end
    return p;
  endfunction

  // Model sees the same edge as the design, so writes land one edge later
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regs <= '{32'h2001, 32'h0300, 32'h0654, 0, 0, 0};
      exp_pins <= 6'h00;
    end else begin
      exp_pins <= route(status_in);
      if (wr_en && addr < 6) regs[addr] <= wr_data;
    end
  end

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Pins are compared every cycle once settled
  always @(negedge ref_clk) begin
    if (!reset) check({10'h000, pin_out}, {10'h000, exp_pins});
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    check(rd_data, exp);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("ERROR %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    reset = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wr_data = 16'h0000;
    status_in = 15'h0000;
    rng = 32'h00000019;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    // Defaults, unmapped space and a write to the read-only monitor
    rd(4'h0, 16'h2001);
    rd(4'h1, 16'h0300);
    rd(4'h2, 16'h0654);
    rd(4'h3, 16'h0000);
    rd(4'h4, 16'h0000);
    rd(4'h5, 16'h0000);
    rd(4'h9, 16'h0000);
    wr(4'h6, 16'hFFFF);
    rd(4'h6, 16'h0000);
    $display("test reset done");
    // Free 25/26 and hand it to the brake
    wr(4'h0, 16'h2000);
    wr(4'h1, 16'h0100);
    @(posedge ref_clk);
    status_in <= 15'h0041;
    repeat (2) @(negedge ref_clk);
    check({15'h0000, pin_out[0]}, 16'h0001);
    wr(4'h4, 16'h0001);
    repeat (2) @(negedge ref_clk);
    check({15'h0000, pin_out[0]}, 16'h0000);
    wr(4'h4, 16'h0000);
    @(posedge ref_clk);
    status_in <= 15'h0001;
    repeat (2) @(negedge ref_clk);
    check({15'h0000, pin_out[0]}, 16'h0000);
    $display("test brake done");
    // Every routing code on one signal, all else cleared
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0000);
    status_in <= 15'h0100;
    for (int c = 0; c < 7; c++) begin
      wr(4'h2, 16'(c));
      repeat (2) @(negedge ref_clk);
      check({10'h000, pin_out}, (c == 0) ? 16'h0000 : 16'(1 << (c - 1)));
    end
    $display("test codes done");
    // Each polarity digit alone
    wr(4'h2, 16'h0000);
    for (int q = 0; q < 6; q++) begin
      wr(4'h4, (q < 4) ? 16'(1 << (4 * q)) : 16'h0000);
      wr(4'h5, (q < 4) ? 16'h0000 : 16'(1 << (4 * (q - 4))));
      repeat (2) @(negedge ref_clk);
      check({10'h000, pin_out}, 16'(1 << q));
    end
    $display("test polarity done");
    // Upper programmable and auxiliary signals, each on its own position
    wr(4'h5, 16'h0000);
    wr(4'h2, 16'h4000);
    wr(4'h3, 16'h0265);
    status_in <= 15'h7800;
    repeat (2) @(negedge ref_clk);
    check({10'h000, pin_out}, 16'h003A);
    $display("test auxiliary done");
    // Random routing, polarity and status with monitor reads
    for (int n = 0; n < 300; n++) begin
      r = xs();
      if (r[3:0] < 4'h6) wr(r[3:0], r[31:16] & 16'h7777);
      @(posedge ref_clk);
      status_in <= r[30:16];
      if (n % 8 == 0) begin
        repeat (3) @(posedge ref_clk);
        rd(4'h6, {10'h000, exp_pins});
        check({10'h000, load_state}, {10'h000, pin_out});
      end
    end
    $display("test random done");
    complete_run();
  end
endmodule
